// ### logic/asram_host.sv
`timescale 1ns/10ps
// Functional notes
// - Write strobe stays high throughout every read cycle.
// - All selects and strobe are high whenever the address changes during writes.
// - Write strobe low pulse lasts at least 45 ns.
// - Host never drives data while the device drives it.
// - Address is valid no later than chip select or lane select falling.
// - Read cycles spaced at least 55 ns; old data held 10 ns.
// - Address valid at least 50 ns before write end; setup and recovery 0.
// - Chip select and lane select low at least 50 ns before write end.
// - Write data stable at least 25 ns before write end; hold 0.
// - Retention needs chip select near supply; supply may drop to 1.5 V.
// - After supply returns, wait one read cycle before any access.
module asram_host
  import asram_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_req_valid,
  input wire asram_req_s i_req,
  output logic o_req_ready,
  output logic o_rd_valid,
  output logic [ASRAM_DATA_W-1:0] o_rd_data,
  input wire logic i_retain,
  output logic o_retain_ack,
  output logic [ASRAM_ADDR_W-1:0] o_word_address,
  output logic o_chip_select_n,
  output logic o_write_strobe_n,
  output logic o_output_enable_n,
  output logic o_low_lane_select_n,
  output logic o_high_lane_select_n,
  input wire logic [ASRAM_DATA_W-1:0] i_data_bus,
  output logic [ASRAM_DATA_W-1:0] o_data_bus,
  output logic o_data_bus_oe_n
);
  asram_state_e state_q;
  asram_state_e state_d;
  logic [ASRAM_CNT_W-1:0] cnt_q;
  logic [ASRAM_CNT_W-1:0] cnt_d;
  asram_ctl_s ctl_q;
  asram_ctl_s ctl_d;
  logic [ASRAM_ADDR_W-1:0] addr_q;
  logic [ASRAM_DATA_W-1:0] wdata_q;
  logic bus_oe_n_q;
  logic bus_oe_n_d;
  logic ready_q;
  logic rd_valid_q;
  logic [ASRAM_DATA_W-1:0] rd_data_q;
  logic retain_ack_q;
  logic lo_en_q;
  logic hi_en_q;
  logic is_write_q;
  logic [ASRAM_DATA_W-1:0] data_sync;
  logic take;
  logic cnt_done;

  // Data pins come from another timing domain, so they are resynchronised.
  asram_sync2 #(.WIDTH(ASRAM_DATA_W)) u_data_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_async(i_data_bus),
    .o_sync(data_sync)
  );

  assign cnt_done = (cnt_q == ASRAM_CNT_ZERO);
  assign take = (state_q == ASRAM_ST_IDLE) && i_req_valid && !i_retain && cnt_done;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_done ? cnt_q : cnt_q - ASRAM_CNT_ONE;
    ctl_d = ctl_q;
    bus_oe_n_d = bus_oe_n_q;
    case (state_q)
      ASRAM_ST_IDLE: begin
        ctl_d = ASRAM_CTL_IDLE;
        if (i_retain) begin
          ctl_d = ASRAM_CTL_IDLE;
        end else if (take && !i_req.write) begin
          ctl_d.write_strobe_n = 1'b1;
          ctl_d.chip_select_n = 1'b0;
          ctl_d.output_enable_n = 1'b0;
          ctl_d.low_lane_select_n = !i_req.low_lane_en;
          ctl_d.high_lane_select_n = !i_req.high_lane_en;
          cnt_d = ASRAM_RD_CNT;
          state_d = ASRAM_ST_RSEL;
        end else if (take) begin
          state_d = ASRAM_ST_WSET;
        end
      end
      ASRAM_ST_RSEL: begin
        if (cnt_done) begin
          ctl_d = ASRAM_CTL_IDLE;
          cnt_d = ASRAM_FLOAT_CNT;
          state_d = ASRAM_ST_RDONE;
        end
      end
      ASRAM_ST_RDONE: begin
        if (cnt_done) begin
          state_d = ASRAM_ST_IDLE;
        end
      end
      ASRAM_ST_WSET: begin
        ctl_d.chip_select_n = 1'b0;
        ctl_d.output_enable_n = 1'b1;
        ctl_d.write_strobe_n = 1'b0;
        ctl_d.low_lane_select_n = !lo_en_q;
        ctl_d.high_lane_select_n = !hi_en_q;
        bus_oe_n_d = 1'b0;
        cnt_d = ASRAM_WR_CNT;
        state_d = ASRAM_ST_WSTRB;
      end
      ASRAM_ST_WSTRB: begin
        if (cnt_done) begin
          ctl_d = ASRAM_CTL_IDLE;
          state_d = ASRAM_ST_REC;
        end
      end
      ASRAM_ST_REC: begin
        bus_oe_n_d = 1'b1;
        state_d = ASRAM_ST_IDLE;
      end
      default: begin
        state_d = ASRAM_ST_IDLE;
        ctl_d = ASRAM_CTL_IDLE;
        bus_oe_n_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_q <= ASRAM_ST_IDLE;
      ctl_q <= ASRAM_CTL_IDLE;
      bus_oe_n_q <= 1'b1;
    end else begin
      state_q <= state_d;
      ctl_q <= ctl_d;
      bus_oe_n_q <= bus_oe_n_d;
    end
  end

  // Counter also enforces recovery after retention and after reset.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cnt_q <= ASRAM_REC_CNT;
    end else if (i_retain && state_q == ASRAM_ST_IDLE) begin
      // Reload only from idle, so an access in flight keeps its timing and read capture.
      // Recovery after retention.
      cnt_q <= ASRAM_REC_CNT;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Request fields are latched at acceptance and held for the whole access.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      addr_q <= ASRAM_ADDR_RST;
      wdata_q <= ASRAM_DATA_RST;
      lo_en_q <= 1'b0;
      hi_en_q <= 1'b0;
      is_write_q <= 1'b0;
    end else if (take) begin
      addr_q <= i_req.word_address;
      wdata_q <= i_req.wdata;
      lo_en_q <= i_req.low_lane_en;
      hi_en_q <= i_req.high_lane_en;
      is_write_q <= i_req.write;
    end
  end

  // Read data is sampled at the end of the select window; lanes not chosen read zero.
  // Sampling goes through the synchroniser, so it lags two edges behind the pins.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= ASRAM_DATA_RST;
    end else begin
      rd_valid_q <= 1'b0;
      if (state_q == ASRAM_ST_RDONE && cnt_q == ASRAM_FLOAT_CNT && !is_write_q) begin
        rd_valid_q <= 1'b1;
        rd_data_q[ASRAM_LANE_W-1:0] <= lo_en_q ? data_sync[ASRAM_LANE_W-1:0] : 8'h00;
        rd_data_q[ASRAM_DATA_W-1:ASRAM_LANE_W] <=
          hi_en_q ? data_sync[ASRAM_DATA_W-1:ASRAM_LANE_W] : 8'h00;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ready_q <= 1'b0;
      retain_ack_q <= 1'b0;
    end else begin
      ready_q <= (state_d == ASRAM_ST_IDLE) && !i_retain && (cnt_d == ASRAM_CNT_ZERO);
      retain_ack_q <= i_retain && (state_q == ASRAM_ST_IDLE);
    end
  end

  assign o_req_ready = ready_q;
  assign o_rd_valid = rd_valid_q;
  assign o_rd_data = rd_data_q;
  assign o_retain_ack = retain_ack_q;
  assign o_word_address = addr_q;
  assign o_chip_select_n = ctl_q.chip_select_n;
  assign o_write_strobe_n = ctl_q.write_strobe_n;
  assign o_output_enable_n = ctl_q.output_enable_n;
  assign o_low_lane_select_n = ctl_q.low_lane_select_n;
  assign o_high_lane_select_n = ctl_q.high_lane_select_n;
  assign o_data_bus = wdata_q;
  assign o_data_bus_oe_n = bus_oe_n_q;
endmodule

// ### logic/asram_pkg.sv
package asram_pkg;

  localparam int unsigned ASRAM_CLK_PERIOD_NS = 25;
  localparam int unsigned ASRAM_ADDR_W = 16;
  localparam int unsigned ASRAM_DATA_W = 16;
  localparam int unsigned ASRAM_LANE_W = 8;

  // Device timing limits, in ns.
  localparam int unsigned ASRAM_T_READ_CYCLE_NS = 55;
  localparam int unsigned ASRAM_T_ACCESS_NS = 55;
  localparam int unsigned ASRAM_T_OE_ACCESS_NS = 30;
  localparam int unsigned ASRAM_T_FLOAT_MAX_NS = 25;
  localparam int unsigned ASRAM_T_WRITE_CYCLE_NS = 55;
  localparam int unsigned ASRAM_T_STROBE_MIN_NS = 45;
  localparam int unsigned ASRAM_T_SELECT_TO_END_NS = 50;
  localparam int unsigned ASRAM_T_DATA_SETUP_NS = 25;
  localparam int unsigned ASRAM_T_RECOVERY_NS = 55;

  // Least times round up to whole cycles.
  localparam int unsigned ASRAM_RD_CYC =
    (ASRAM_T_ACCESS_NS + ASRAM_CLK_PERIOD_NS - 1) / ASRAM_CLK_PERIOD_NS;
  localparam int unsigned ASRAM_FLOAT_CYC =
    (ASRAM_T_FLOAT_MAX_NS + ASRAM_CLK_PERIOD_NS - 1) / ASRAM_CLK_PERIOD_NS;
  localparam int unsigned ASRAM_WR_CYC =
    (ASRAM_T_SELECT_TO_END_NS + ASRAM_CLK_PERIOD_NS - 1) / ASRAM_CLK_PERIOD_NS;
  localparam int unsigned ASRAM_REC_CYC =
    (ASRAM_T_RECOVERY_NS + ASRAM_CLK_PERIOD_NS - 1) / ASRAM_CLK_PERIOD_NS;
  localparam int unsigned ASRAM_CNT_W = 3;

  localparam logic [ASRAM_CNT_W-1:0] ASRAM_RD_CNT = ASRAM_CNT_W'(ASRAM_RD_CYC);
  localparam logic [ASRAM_CNT_W-1:0] ASRAM_FLOAT_CNT = ASRAM_CNT_W'(ASRAM_FLOAT_CYC);
  localparam logic [ASRAM_CNT_W-1:0] ASRAM_WR_CNT = ASRAM_CNT_W'(ASRAM_WR_CYC);
  localparam logic [ASRAM_CNT_W-1:0] ASRAM_REC_CNT = ASRAM_CNT_W'(ASRAM_REC_CYC);
  localparam logic [ASRAM_CNT_W-1:0] ASRAM_CNT_ZERO = 3'h0;
  localparam logic [ASRAM_CNT_W-1:0] ASRAM_CNT_ONE = 3'h1;

  typedef enum logic [5:0] {
    ASRAM_ST_IDLE  = 6'h01,
    ASRAM_ST_RSEL  = 6'h02,
    ASRAM_ST_RDONE = 6'h04,
    ASRAM_ST_WSET  = 6'h08,
    ASRAM_ST_WSTRB = 6'h10,
    ASRAM_ST_REC   = 6'h20
  } asram_state_e;

  typedef struct packed {
    logic write;
    logic [ASRAM_ADDR_W-1:0] word_address;
    logic [ASRAM_DATA_W-1:0] wdata;
    logic low_lane_en;
    logic high_lane_en;
  } asram_req_s;

  typedef struct packed {
    logic chip_select_n;
    logic write_strobe_n;
    logic output_enable_n;
    logic low_lane_select_n;
    logic high_lane_select_n;
  } asram_ctl_s;

  localparam asram_ctl_s ASRAM_CTL_IDLE = 5'h1f;
  localparam logic [ASRAM_ADDR_W-1:0] ASRAM_ADDR_RST = 16'h0000;
  localparam logic [ASRAM_DATA_W-1:0] ASRAM_DATA_RST = 16'h0000;

endpackage

// ### logic/asram_sync2.sv
`timescale 1ns/10ps
module asram_sync2 #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule

// ### verif/asram_host_assertions.sv
`timescale 1ns/10ps
module asram_chk
  import asram_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_req_valid,
  input wire asram_req_s i_req,
  input wire logic i_retain,
  input wire logic o_req_ready,
  input wire logic o_rd_valid,
  input wire logic [ASRAM_ADDR_W-1:0] o_word_address,
  input wire logic o_chip_select_n,
  input wire logic o_write_strobe_n,
  input wire logic o_output_enable_n,
  input wire logic o_low_lane_select_n,
  input wire logic o_high_lane_select_n,
  input wire logic o_data_bus_oe_n
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  logic rd_take;
  assign rd_take = i_req_valid && o_req_ready && !i_retain && !i_req.write;
  property p_rd_we; !o_output_enable_n |-> o_write_strobe_n; endproperty
  a_rd_we: assert property (p_rd_we) else $error("strobe low in read");
  property p_adr; $changed(o_word_address) && o_output_enable_n |-> o_chip_select_n &&
    o_write_strobe_n && o_low_lane_select_n && o_high_lane_select_n; endproperty
  a_adr: assert property (p_adr) else $error("address moved while selected");
  property p_wpw; $fell(o_write_strobe_n) |-> !o_write_strobe_n [*2]; endproperty
  a_wpw: assert property (p_wpw) else $error("strobe pulse short");
  property p_own; !o_data_bus_oe_n |-> o_output_enable_n; endproperty
  a_own: assert property (p_own) else $error("data driven in read");
  property p_wadr; !o_write_strobe_n |-> $stable(o_word_address); endproperty
  a_wadr: assert property (p_wadr) else $error("address moved in write");
  property p_wsel; $rose(o_write_strobe_n) |-> !$past(o_chip_select_n, 2); endproperty
  a_wsel: assert property (p_wsel) else $error("select late in write");
  property p_wdat; $rose(o_write_strobe_n) |-> !$past(o_data_bus_oe_n, 2); endproperty
  a_wdat: assert property (p_wdat) else $error("write data late");
  property p_rans; rd_take |-> ##6 o_rd_valid; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  c_rd: cover property (rd_take);
  c_wr: cover property ($fell(o_write_strobe_n));
  c_ret: cover property (i_retain && o_chip_select_n);
endmodule

// ### verif/asram_dev.sv
`timescale 1ns/10ps
module asram_dev
  import asram_pkg::*;
(
  input wire logic [ASRAM_ADDR_W-1:0] i_adr,
  input wire logic i_cs_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic [1:0] i_lane_n,
  input wire logic [ASRAM_DATA_W-1:0] i_bus,
  output logic [ASRAM_DATA_W-1:0] o_q,
  output logic [1:0] o_en
);
  logic [ASRAM_DATA_W-1:0] mem [2**ASRAM_ADDR_W];
  logic [ASRAM_DATA_W-1:0] w;
  logic [1:0] rd, dv;
  assign rd = {2{!i_cs_n && !i_oe_n && i_we_n}} & ~i_lane_n;
  assign #10 o_en = rd;
  assign #55 dv = rd;
  assign w = mem[i_adr];
  // Before the access time the lanes show inverted data, so early samples fail.
  assign o_q = {dv[1] ? w[15:8] : ~w[15:8], dv[0] ? w[7:0] : ~w[7:0]};
  always @* begin
    if (!i_cs_n && !i_we_n && !i_lane_n[0]) mem[i_adr][7:0] = i_bus[7:0];
    if (!i_cs_n && !i_we_n && !i_lane_n[1]) mem[i_adr][15:8] = i_bus[15:8];
  end
endmodule

// ### verif/tb.sv
`timescale 1ns/10ps
module tb;
  import asram_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic vld = 1'h0;
  logic ret = 1'h0;
  asram_req_s req = '0;
  logic rdy, rdv, ack, cs_n, we_n, oe_n, lb_n, ub_n, doe_n;
  logic [1:0] den;
  logic [15:0] rdd, adr, dout, dq, bus;
  logic [15:0] last = 16'h0000;
  int fail_count = 0;
  int comparisons = 0;
  initial forever #12.5 clk = ~clk;
  asram_host uut (.i_clk_sys(clk), .i_rst(rst), .i_req_valid(vld), .i_req(req),
    .o_req_ready(rdy), .o_rd_valid(rdv), .o_rd_data(rdd), .i_retain(ret),
    .o_retain_ack(ack), .o_word_address(adr), .o_chip_select_n(cs_n),
    .o_write_strobe_n(we_n), .o_output_enable_n(oe_n), .o_low_lane_select_n(lb_n),
    .o_high_lane_select_n(ub_n), .i_data_bus(bus), .o_data_bus(dout),
    .o_data_bus_oe_n(doe_n));
  asram_dev dev (.i_adr(adr), .i_cs_n(cs_n), .i_we_n(we_n), .i_oe_n(oe_n),
    .i_lane_n({ub_n, lb_n}), .i_bus(bus), .o_q(dq), .o_en(den));
  // A floating lane shows last cycle inverted, so no stale value can match.
  always_comb begin
    for (int l = 0; l < 2; l++) begin
      bus[l*8+:8] = !doe_n ? dout[l*8+:8] : den[l] ? dq[l*8+:8] : ~last[l*8+:8];
    end
  end
  always @(posedge clk) last <= bus;
  task chk(input string n, input logic [15:0] e, s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task test_done;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task xfer(input logic w, input logic [15:0] a, d, input logic [1:0] ln);
    repeat (2) @(posedge clk);
    #1;
    for (int n = 0; n < 20 && rdy !== 1'h1; n++) begin
      @(posedge clk);
      #1;
    end
    chk("ready", 16'h1, {15'h0, rdy});
    @(posedge clk);
    vld <= 1'h1;
    req <= '{w, a, d, ln[0], ln[1]};
    @(posedge clk);
    vld <= 1'h0;
  endtask
  task wr(input logic [15:0] a, d, input logic [1:0] ln);
    xfer(1'h1, a, d, ln);
    repeat (2) @(posedge clk);
    #1;
    chk("wr_strobe", 16'h0, {15'h0, we_n | doe_n});
    repeat (5) @(posedge clk);
    #1;
    chk("data_oe_n", 16'h1, {15'h0, doe_n});
  endtask
  task rd(input logic [15:0] a, e, input logic [1:0] ln);
    xfer(1'h0, a, 16'h0000, ln);
    // Select window, float wait, then the capture edge.
    repeat (ASRAM_RD_CYC + ASRAM_FLOAT_CYC + 1) @(posedge clk);
    #1;
    chk("rd_valid", 16'h1, {15'h0, rdv});
    chk("rd_data", e, rdd);
  endtask
  task t_rst;
    chk("ctl", {11'h0, ASRAM_CTL_IDLE}, {11'h0, cs_n, we_n, oe_n, lb_n, ub_n});
    chk("data_oe_n", 16'h1, {15'h0, doe_n});
  endtask
  task t_lanes;
    wr(16'hffff, 16'h1234, 2'h3);
    wr(16'hffff, 16'habcd, 2'h1);
    wr(16'hffff, 16'h5566, 2'h0);
    rd(16'hffff, 16'h12cd, 2'h3);
    rd(16'hffff, 16'h1200, 2'h2);
    rd(16'hffff, 16'h00cd, 2'h1);
    wr(16'h0000, 16'ha55a, 2'h2);
    rd(16'h0000, 16'ha500, 2'h2);
  endtask
  task t_retain;
    @(posedge clk);
    ret <= 1'h1;
    for (int n = 0; n < 20 && ack !== 1'h1; n++) begin
      @(posedge clk);
      #1;
    end
    chk("retain_cs", 16'h1, {15'h0, cs_n & lb_n & ub_n & ack});
    @(posedge clk);
    vld <= 1'h1;
    req <= '{1'h0, 16'hffff, 16'h0000, 1'h1, 1'h1};
    repeat (3) @(posedge clk);
    #1;
    chk("refused", 16'h1, {15'h0, !rdy & oe_n});
    @(posedge clk);
    vld <= 1'h0;
    ret <= 1'h0;
    @(posedge clk);
    #1;
    chk("recovery", 16'h0, {15'h0, rdy});
    rd(16'hffff, 16'h12cd, 2'h3);
  endtask
  task t_abort;
    xfer(1'h1, 16'hffff, 16'h7777, 2'h3);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rd(16'hffff, 16'h12cd, 2'h3);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1;
    t_rst;
    @(posedge clk);
    rst <= 1'h0;
    t_lanes;
    t_retain;
    t_abort;
    test_done;
  end
  // The sequence needs some 135 cycles; over twenty times that means a hang.
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    test_done;
  end
endmodule
bind asram_host asram_chk u_chk (.i_clk_sys, .i_rst, .i_req_valid, .i_req, .i_retain,
  .o_req_ready, .o_rd_valid, .o_word_address, .o_chip_select_n, .o_write_strobe_n,
  .o_output_enable_n, .o_low_lane_select_n, .o_high_lane_select_n, .o_data_bus_oe_n);
